/* File: inc/cca_params.svh */
// register offsets, field positions, reset values and timing figures of the calendar clock
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CCA_OFS_FLAGS     8'h40
`define CCA_OFS_IRQ_EN    8'h41
`define CCA_OFS_CTRL2     8'h43
`define CCA_OFS_SECOND    8'h44
`define CCA_OFS_MINUTE    8'h45
`define CCA_OFS_HOUR      8'h46
`define CCA_OFS_DAY       8'h47
`define CCA_OFS_WEEKDAY   8'h48
`define CCA_OFS_MONTH     8'h49
`define CCA_OFS_YEAR      8'h4a
`define CCA_OFS_ALM_MIN   8'h4b
`define CCA_OFS_ALM_HOUR  8'h4c
`define CCA_OFS_STOPWATCH 8'h4d

// ---------------------------------------------------------------
// flag and enable bit positions (same layout in both registers)
// ---------------------------------------------------------------
`define CCA_BIT_SECOND 0
`define CCA_BIT_MINUTE 1
`define CCA_BIT_HOUR   2
`define CCA_BIT_DAY    3
`define CCA_BIT_ALARM  4
`define CCA_BIT_TB_A   5
`define CCA_BIT_TB_B   6
`define CCA_FLAG_BITS  7

// ---------------------------------------------------------------
// control register 2 fields
// ---------------------------------------------------------------
`define CCA_BIT_MOD_EN 0
`define CCA_BIT_SW_EN  1
`define CCA_BIT_SW_CLR 2

// ---------------------------------------------------------------
// limits and reset values
// ---------------------------------------------------------------
`define CCA_SEC_MAX    8'h3b
`define CCA_MIN_MAX    8'h3b
`define CCA_HOUR_MAX   8'h17
`define CCA_WDAY_MAX   8'h06
`define CCA_MONTH_MAX  8'h0c
`define CCA_YEAR_MIN   8'h01
`define CCA_YEAR_MAX   8'hc7
`define CCA_CENTI_MAX  8'h63
`define CCA_RST_ZERO   8'h00
`define CCA_RST_ONE    8'h01

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CCA_CLOCK_PERIOD_NS 50
`define CCA_CENTI_PERIOD_NS 10000000
`define CCA_CENTI_CYCLES    (`CCA_CENTI_PERIOD_NS / `CCA_CLOCK_PERIOD_NS)
`define CCA_CENTI_PER_TB_B  25
`define CCA_CENTI_PER_TB_A  50

`endif

/* File: inc/cca_pkg.sv */
// shared types and calendar arithmetic of the calendar clock
`include "cca_params.svh"

package cca_pkg;

  typedef logic [7:0] cca_byte_t;
  typedef logic [`CCA_FLAG_BITS-1:0] cca_flags_t;

  // year is held as an offset from 1900; every fourth year in 1901..2099 is a leap year
  function automatic logic cca_is_leap(input cca_byte_t year);
    return (year[1:0] == 2'b00);
  endfunction

  function automatic cca_byte_t cca_month_days(input cca_byte_t month, input cca_byte_t year);
    case (month)
      8'h02:   return cca_is_leap(year) ? 8'h1d : 8'h1c;
      8'h04,
      8'h06,
      8'h09,
      8'h0b:   return 8'h1e;
      default: return 8'h1f;
    endcase
  endfunction

endpackage

/* File: src/cca_divider.sv */
// divider chain: hundredth-second, 4 Hz, 2 Hz and 1 Hz ticks
`include "cca_params.svh"

module cca_divider #(
  parameter int unsigned CENTI_CYCLES = `CCA_CENTI_CYCLES
) (
  input  wire logic clock,     // system clock
  input  wire logic resetn,    // synchronous reset, active low
  input  wire logic run,       // module enable; holds the chain when low
  output logic      tick_centi, // one-cycle pulse every 1/100 s
  output logic      tick_4hz,  // one-cycle pulse at 4 Hz
  output logic      tick_2hz,  // one-cycle pulse at 2 Hz
  output logic      tick_1hz   // one-cycle pulse at 1 Hz
);

  localparam int CW = $clog2(CENTI_CYCLES + 1);

  generate
    if (CENTI_CYCLES < 2) begin : g_check
      $error("cca_divider: CENTI_CYCLES must be at least 2");
    end
  endgenerate

  logic [CW-1:0]         cyc_cnt;
  logic [CW-1:0]         next_cyc_cnt;
  cca_pkg::cca_byte_t    centi_cnt;
  cca_pkg::cca_byte_t    next_centi_cnt;
  logic                  next_tick_centi;
  logic                  next_tick_4hz;
  logic                  next_tick_2hz;
  logic                  next_tick_1hz;
  logic                  wrap;

  always_comb begin
    wrap            = run && (cyc_cnt == CW'(CENTI_CYCLES - 1));
    next_cyc_cnt    = cyc_cnt;
    next_centi_cnt  = centi_cnt;
    next_tick_centi = wrap;
    next_tick_4hz   = 1'b0;
    next_tick_2hz   = 1'b0;
    next_tick_1hz   = 1'b0;
    if (run) begin
      next_cyc_cnt = wrap ? '0 : cyc_cnt + CW'(1);
    end
    if (wrap) begin
      next_centi_cnt = (centi_cnt == `CCA_CENTI_MAX) ? `CCA_RST_ZERO : centi_cnt + 8'h01;
      next_tick_4hz  = ((centi_cnt + 8'h01) % 8'(`CCA_CENTI_PER_TB_B)) == 8'h00;
      next_tick_2hz  = ((centi_cnt + 8'h01) % 8'(`CCA_CENTI_PER_TB_A)) == 8'h00;
      next_tick_1hz  = (centi_cnt == `CCA_CENTI_MAX);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cyc_cnt    <= '0;
      centi_cnt  <= `CCA_RST_ZERO;
      tick_centi <= 1'b0;
      tick_4hz   <= 1'b0;
      tick_2hz   <= 1'b0;
      tick_1hz   <= 1'b0;
    end else begin
      cyc_cnt    <= next_cyc_cnt;
      centi_cnt  <= next_centi_cnt;
      tick_centi <= next_tick_centi;
      tick_4hz   <= next_tick_4hz;
      tick_2hz   <= next_tick_2hz;
      tick_1hz   <= next_tick_1hz;
    end
  end

endmodule

/* File: src/cca_calendar.sv */
// calendar counters: day, weekday, month and year with month-length and leap-year roll-over
`include "cca_params.svh"

module cca_calendar (
  input  wire logic               clock,    // system clock
  input  wire logic               resetn,   // synchronous reset, active low
  input  wire logic               day_step, // one-cycle pulse: advance one day
  input  wire logic               wr_day,   // software write of day
  input  wire logic               wr_wday,  // software write of weekday
  input  wire logic               wr_month, // software write of month
  input  wire logic               wr_year,  // software write of year
  input  wire cca_pkg::cca_byte_t wdata,    // write data
  output cca_pkg::cca_byte_t      day,      // day of month, 1 based
  output cca_pkg::cca_byte_t      wday,     // day of week, 0..6
  output cca_pkg::cca_byte_t      month,    // month, 1..12
  output cca_pkg::cca_byte_t      year      // year minus 1900, 1..199
);

  cca_pkg::cca_byte_t next_day;
  cca_pkg::cca_byte_t next_wday;
  cca_pkg::cca_byte_t next_month;
  cca_pkg::cca_byte_t next_year;

  always_comb begin
    next_day   = day;
    next_wday  = wday;
    next_month = month;
    next_year  = year;
    if (day_step) begin
      next_wday = (wday >= `CCA_WDAY_MAX) ? `CCA_RST_ZERO : wday + 8'h01;
      if (day >= cca_pkg::cca_month_days(month, year)) begin
        next_day = `CCA_RST_ONE;
        if (month >= `CCA_MONTH_MAX) begin
          next_month = `CCA_RST_ONE;
          // 2099 rolls back to 1901, keeping the year inside its range
          next_year  = (year >= `CCA_YEAR_MAX) ? `CCA_YEAR_MIN : year + 8'h01;
        end else begin
          next_month = month + 8'h01;
        end
      end else begin
        next_day = day + 8'h01;
      end
    end
    // a software write wins over the roll-over in the same cycle
    if (wr_day) begin
      next_day = wdata;
    end
    if (wr_wday) begin
      next_wday = wdata;
    end
    if (wr_month) begin
      next_month = wdata;
    end
    if (wr_year) begin
      next_year = wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      day   <= `CCA_RST_ONE;
      wday  <= `CCA_RST_ZERO;
      month <= `CCA_RST_ONE;
      year  <= `CCA_YEAR_MIN;
    end else begin
      day   <= next_day;
      wday  <= next_wday;
      month <= next_month;
      year  <= next_year;
    end
  end

endmodule

/* File: src/cca_top.sv */
// calendar clock with alarm, timebase flags and stopwatch, behind a simple register port
//
// Behaviour
// - seconds, minutes, hours set flags, interrupt if enabled
// - day, weekday, month, year; month-aware day roll-over
// - year spans 1901 through 2099
// - day flag on each day step, interrupt if enabled
// - alarm flag on hour and minute match
// - 2 Hz and 4 Hz timebase flags, each enabled
// - stopwatch clear zeroes count, self-clears, reads zero
// - stopwatch clear touches nothing but the count
// - enabled stopwatch counts up each hundredth second
// - disabled stopwatch holds its count
// - module enable gates all counting, keeps contents
// - reset clears stopwatch clear, stopwatch and module enable
//
// Decided for this implementation: strobed register access.
`include "cca_params.svh"

module cca_top #(
  parameter int unsigned CENTI_CYCLES = `CCA_CENTI_CYCLES
) (
  input  wire logic               clock,  // 20 MHz system clock
  input  wire logic               resetn, // synchronous reset, active low
  input  wire cca_pkg::cca_byte_t addr,   // register address
  input  wire cca_pkg::cca_byte_t wdata,  // write data
  input  wire logic               wr,     // write strobe, one cycle
  input  wire logic               rd,     // read strobe, one cycle
  output cca_pkg::cca_byte_t      rdata,  // read data, valid the cycle after rd
  output logic                    irq     // interrupt request, active high level
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    // the divider needs two cycles per hundredth to form its tick
    if (CENTI_CYCLES < 2) begin : g_check_centi
      $error("cca_top: CENTI_CYCLES must be at least 2");
    end
    // flags and enables are read back beside a zero top bit
    if (`CCA_FLAG_BITS != 7) begin : g_check_flags
      $error("cca_top: the flag layout must be seven bits wide");
    end
    // the timebase periods, in hundredths, must divide the hundred hundredths of one second evenly
    if ((((`CCA_CENTI_MAX + 1) % `CCA_CENTI_PER_TB_A) != 0) ||
        (((`CCA_CENTI_MAX + 1) % `CCA_CENTI_PER_TB_B) != 0)) begin : g_check_tb
      $error("cca_top: the timebase periods must divide one second");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cca_pkg::cca_flags_t flags;
  cca_pkg::cca_flags_t next_flags;
  cca_pkg::cca_flags_t irq_en;
  cca_pkg::cca_flags_t next_irq_en;
  logic                mod_en;
  logic                next_mod_en;
  logic                sw_en;
  logic                next_sw_en;
  cca_pkg::cca_byte_t  second;
  cca_pkg::cca_byte_t  next_second;
  cca_pkg::cca_byte_t  minute;
  cca_pkg::cca_byte_t  next_minute;
  cca_pkg::cca_byte_t  hour;
  cca_pkg::cca_byte_t  next_hour;
  cca_pkg::cca_byte_t  alm_min;
  cca_pkg::cca_byte_t  next_alm_min;
  cca_pkg::cca_byte_t  alm_hour;
  cca_pkg::cca_byte_t  next_alm_hour;
  cca_pkg::cca_byte_t  stopwatch;
  cca_pkg::cca_byte_t  next_stopwatch;
  logic                alm_match;
  logic                next_alm_match;
  cca_pkg::cca_byte_t  next_rdata;
  logic                next_irq;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  function automatic logic wr_hit(input cca_pkg::cca_byte_t ofs);
    return wr && (addr == ofs);
  endfunction

  function automatic logic rd_hit(input cca_pkg::cca_byte_t ofs);
    return rd && (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // divider chain and calendar
  // ---------------------------------------------------------------
  logic               tick_centi;
  logic               tick_4hz;
  logic               tick_2hz;
  logic               tick_1hz;
  logic               day_step;
  cca_pkg::cca_byte_t day;
  cca_pkg::cca_byte_t wday;
  cca_pkg::cca_byte_t month;
  cca_pkg::cca_byte_t year;

  // the divider holds its phase while the module is off, so time resumes where it stopped
  cca_divider #(
    .CENTI_CYCLES (CENTI_CYCLES)
  ) u_divider (
    .clock      (clock),
    .resetn     (resetn),
    .run        (mod_en),
    .tick_centi (tick_centi),
    .tick_4hz   (tick_4hz),
    .tick_2hz   (tick_2hz),
    .tick_1hz   (tick_1hz)
  );

  cca_calendar u_calendar (
    .clock    (clock),
    .resetn   (resetn),
    .day_step (day_step),
    .wr_day   (wr_hit(`CCA_OFS_DAY)),
    .wr_wday  (wr_hit(`CCA_OFS_WEEKDAY)),
    .wr_month (wr_hit(`CCA_OFS_MONTH)),
    .wr_year  (wr_hit(`CCA_OFS_YEAR)),
    .wdata    (wdata),
    .day      (day),
    .wday     (wday),
    .month    (month),
    .year     (year)
  );

  // ---------------------------------------------------------------
  // time of day, alarm, stopwatch
  // ---------------------------------------------------------------
  cca_pkg::cca_flags_t events;
  logic                step_min;
  logic                step_hour;

  always_comb begin
    next_second    = second;
    next_minute    = minute;
    next_hour      = hour;
    next_stopwatch = stopwatch;
    events         = '0;
    step_min       = 1'b0;
    step_hour      = 1'b0;
    day_step       = 1'b0;

    // a tick in flight can arrive the cycle after the module is cleared, so each is gated with mod_en to freeze everything
    if (tick_1hz && mod_en) begin
      events[`CCA_BIT_SECOND] = 1'b1;
      if (second >= `CCA_SEC_MAX) begin
        next_second = `CCA_RST_ZERO;
        step_min    = 1'b1;
      end else begin
        next_second = second + 8'h01;
      end
    end
    if (step_min) begin
      events[`CCA_BIT_MINUTE] = 1'b1;
      if (minute >= `CCA_MIN_MAX) begin
        next_minute = `CCA_RST_ZERO;
        step_hour   = 1'b1;
      end else begin
        next_minute = minute + 8'h01;
      end
    end
    if (step_hour) begin
      events[`CCA_BIT_HOUR] = 1'b1;
      if (hour >= `CCA_HOUR_MAX) begin
        next_hour = `CCA_RST_ZERO;
        day_step  = 1'b1;
      end else begin
        next_hour = hour + 8'h01;
      end
    end
    events[`CCA_BIT_DAY]  = day_step;
    events[`CCA_BIT_TB_A] = tick_2hz && mod_en;
    events[`CCA_BIT_TB_B] = tick_4hz && mod_en;

    // a software write wins over a roll-over of the same cycle
    if (wr_hit(`CCA_OFS_SECOND)) begin
      next_second = wdata;
    end
    if (wr_hit(`CCA_OFS_MINUTE)) begin
      next_minute = wdata;
    end
    if (wr_hit(`CCA_OFS_HOUR)) begin
      next_hour = wdata;
    end

    // stopwatch runs only with both enables; a clear is taken even while it is held
    if (tick_centi && mod_en && sw_en) begin
      next_stopwatch = (stopwatch >= `CCA_CENTI_MAX) ? `CCA_RST_ZERO : stopwatch + 8'h01;
    end
    if (wr_hit(`CCA_OFS_STOPWATCH)) begin
      next_stopwatch = wdata;
    end
    if (wr_hit(`CCA_OFS_CTRL2) && wdata[`CCA_BIT_SW_CLR]) begin
      next_stopwatch = `CCA_RST_ZERO;
    end

    // alarm fires on entering the match, so it sets once per matching minute
    next_alm_match         = (next_minute == alm_min) && (next_hour == alm_hour);
    events[`CCA_BIT_ALARM] = next_alm_match && !alm_match && mod_en;
  end

  // ---------------------------------------------------------------
  // control, enables and flags
  // ---------------------------------------------------------------
  always_comb begin
    next_mod_en   = mod_en;
    next_sw_en    = sw_en;
    next_irq_en   = irq_en;
    next_alm_min  = alm_min;
    next_alm_hour = alm_hour;
    next_flags    = flags;
    if (wr_hit(`CCA_OFS_CTRL2)) begin
      // the clear bit is a one-shot and is never stored
      next_mod_en = wdata[`CCA_BIT_MOD_EN];
      next_sw_en  = wdata[`CCA_BIT_SW_EN];
    end
    if (wr_hit(`CCA_OFS_IRQ_EN)) begin
      next_irq_en = wdata[`CCA_FLAG_BITS-1:0];
    end
    if (wr_hit(`CCA_OFS_ALM_MIN)) begin
      next_alm_min = wdata;
    end
    if (wr_hit(`CCA_OFS_ALM_HOUR)) begin
      next_alm_hour = wdata;
    end
    // reading the flags clears them; a new event in the same cycle survives
    if (rd_hit(`CCA_OFS_FLAGS)) begin
      next_flags = '0;
    end
    next_flags = next_flags | events;
    // irq follows the flags of the same edge, so a clearing read drops it at once
    next_irq   = |(next_flags & next_irq_en);
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = `CCA_RST_ZERO;
    if (rd) begin
      case (addr)
        `CCA_OFS_FLAGS:     next_rdata = {1'b0, flags};
        `CCA_OFS_IRQ_EN:    next_rdata = {1'b0, irq_en};
        // the clear bit always reads back as zero
        `CCA_OFS_CTRL2:     next_rdata = {6'h00, sw_en, mod_en};
        `CCA_OFS_SECOND:    next_rdata = second;
        `CCA_OFS_MINUTE:    next_rdata = minute;
        `CCA_OFS_HOUR:      next_rdata = hour;
        `CCA_OFS_DAY:       next_rdata = day;
        `CCA_OFS_WEEKDAY:   next_rdata = wday;
        `CCA_OFS_MONTH:     next_rdata = month;
        `CCA_OFS_YEAR:      next_rdata = year;
        `CCA_OFS_ALM_MIN:   next_rdata = alm_min;
        `CCA_OFS_ALM_HOUR:  next_rdata = alm_hour;
        `CCA_OFS_STOPWATCH: next_rdata = stopwatch;
        default:            next_rdata = `CCA_RST_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mod_en    <= 1'b0;
      sw_en     <= 1'b0;
      irq_en    <= '0;
      flags     <= '0;
      second    <= `CCA_RST_ZERO;
      minute    <= `CCA_RST_ZERO;
      hour      <= `CCA_RST_ZERO;
      alm_min   <= `CCA_RST_ZERO;
      alm_hour  <= `CCA_RST_ZERO;
      // starting matched keeps the reset time 00:00 from raising the alarm
      alm_match <= 1'b1;
      stopwatch <= `CCA_RST_ZERO;
      rdata     <= `CCA_RST_ZERO;
      irq       <= 1'b0;
    end else begin
      mod_en    <= next_mod_en;
      sw_en     <= next_sw_en;
      irq_en    <= next_irq_en;
      flags     <= next_flags;
      second    <= next_second;
      minute    <= next_minute;
      hour      <= next_hour;
      alm_min   <= next_alm_min;
      alm_hour  <= next_alm_hour;
      alm_match <= next_alm_match;
      stopwatch <= next_stopwatch;
      rdata     <= next_rdata;
      irq       <= next_irq;
    end
  end

endmodule

/* File: verif/cca_top_monitor.sv */
// concurrent checks on the calendar clock register port and interrupt line
`include "cca_params.svh"

module cca_top_monitor (
  input wire logic               clock,  // system clock
  input wire logic               resetn, // synchronous reset, active low
  input wire cca_pkg::cca_byte_t addr,   // register address
  input wire cca_pkg::cca_byte_t wdata,  // write data
  input wire logic               wr,     // write strobe
  input wire logic               rd,     // read strobe
  input wire cca_pkg::cca_byte_t rdata,  // read data
  input wire logic               irq     // interrupt request
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------
  // shadows of software state
  // ---------------------------------------------------------------
  cca_pkg::cca_byte_t en_q;
  cca_pkg::cca_byte_t ctl_q;
  cca_pkg::cca_byte_t next_en;
  cca_pkg::cca_byte_t next_ctl;
  logic               off_q;
  logic               next_off;

  // off_q lags one cycle so a tick already in flight at switch-off is excused
  always_comb begin
    next_en  = (wr && addr == `CCA_OFS_IRQ_EN) ? wdata : en_q;
    next_ctl = (wr && addr == `CCA_OFS_CTRL2) ? wdata : ctl_q;
    next_off = !ctl_q[`CCA_BIT_MOD_EN];
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      en_q  <= 8'h00;
      ctl_q <= 8'h00;
      off_q <= 1'b1;
    end else begin
      en_q  <= next_en;
      ctl_q <= next_ctl;
      off_q <= next_off;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_RESET_QUIET: assert property (!$past(resetn) |-> rdata == 8'h00 && !irq)
    else $error("port not quiet after reset");
  AST_CLR_READS_ZERO: assert property (rd && addr == `CCA_OFS_CTRL2 |=> !rdata[`CCA_BIT_SW_CLR])
    else $error("stopwatch clear bit read back as one");
  AST_IRQ_HELD: assert property (irq && !(rd && addr == `CCA_OFS_FLAGS) && !(wr && addr == `CCA_OFS_IRQ_EN)
    |=> irq)
    else $error("interrupt dropped without clear");
  AST_IRQ_MATCHES_FLAGS: assert property (rd && addr == `CCA_OFS_FLAGS
    |=> ((rdata[6:0] & en_q[6:0]) != 7'h00) == $past(irq))
    else $error("interrupt differs from enabled flags");
  AST_IDLE_NO_IRQ_RISE: assert property (off_q && !ctl_q[`CCA_BIT_MOD_EN] && !wr |=> !$rose(irq))
    else $error("interrupt rose while module disabled");
  AST_SW_RANGE: assert property (rd && addr == `CCA_OFS_STOPWATCH |=> rdata <= `CCA_CENTI_MAX)
    else $error("stopwatch above 99");
  AST_TIME_RANGE: assert property (rd && (addr == `CCA_OFS_SECOND || addr == `CCA_OFS_MINUTE)
    |=> rdata <= `CCA_SEC_MAX)
    else $error("second or minute above 59");
  AST_DATE_RANGE: assert property (rd && addr == `CCA_OFS_DAY |=> rdata inside {[8'h01:8'h1f]})
    else $error("day out of range");
  AST_YEAR_RANGE: assert property (rd && addr == `CCA_OFS_YEAR |=> rdata inside {[8'h01:8'hc7]})
    else $error("year out of range");
endmodule

bind cca_top cca_top_monitor u_mon (
  .clock  (clock),
  .resetn (resetn),
  .addr   (addr),
  .wdata  (wdata),
  .wr     (wr),
  .rd     (rd),
  .rdata  (rdata),
  .irq    (irq)
);

/* File: verif/tb_top.sv */
// self-checking bench for the calendar clock
`include "cca_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clock;
  logic               resetn;
  cca_pkg::cca_byte_t addr;
  cca_pkg::cca_byte_t wdata;
  logic               wr;
  logic               rd;
  cca_pkg::cca_byte_t rdata;
  logic               irq;
  int                 bad_count;
  int                 n_tests;
  int                 seed;
  int                 d;
  int                 m;
  int                 y;
  cca_pkg::cca_byte_t v;
  cca_pkg::cca_byte_t w;
  cca_pkg::cca_byte_t cm [6] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h04, 8'h0c};
  cca_pkg::cca_byte_t cd [6] = '{8'h1f, 8'h1c, 8'h1c, 8'h1d, 8'h1e, 8'h1f};
  cca_pkg::cca_byte_t cy [6] = '{8'h01, 8'h01, 8'h04, 8'h04, 8'h01, 8'hc7};

  // short divider so a second is 400 cycles
  cca_top #(.CENTI_CYCLES(4)) uut (
    .clock  (clock),
    .resetn (resetn),
    .addr   (addr),
    .wdata  (wdata),
    .wr     (wr),
    .rd     (rd),
    .rdata  (rdata),
    .irq    (irq)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk8(input cca_pkg::cca_byte_t got, input cca_pkg::cca_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input cca_pkg::cca_byte_t a, input cca_pkg::cca_byte_t dv);
    @(posedge clock);
    addr  <= a;
    wdata <= dv;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input cca_pkg::cca_byte_t a, output cca_pkg::cca_byte_t q);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic rdx(input cca_pkg::cca_byte_t a, input cca_pkg::cca_byte_t exp);
    cca_pkg::cca_byte_t q;
    rd_reg(a, q);
    chk8(q, exp);
  endtask

  // model month length, leap year every fourth year offset
  function automatic int mlen(input int mo, input int yr);
    if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction

  initial begin
    #2_000_000;
    bad_count++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 81;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    resetn = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rdx(`CCA_OFS_CTRL2, 8'h00);
    rdx(`CCA_OFS_STOPWATCH, 8'h00);
    rdx(`CCA_OFS_DAY, 8'h01);
    rdx(`CCA_OFS_YEAR, 8'h01);
    wr_reg(8'h42, 8'h5a);
    rdx(8'h42, 8'h00);
    // calendar roll-over at month ends, leap years and year wrap
    wr_reg(`CCA_OFS_ALM_HOUR, 8'h0c);
    wr_reg(`CCA_OFS_ALM_MIN, 8'h22);
    for (int k = 0; k < 6; k++) begin
      wr_reg(`CCA_OFS_CTRL2, 8'h00);
      wr_reg(`CCA_OFS_SECOND, 8'h3b);
      wr_reg(`CCA_OFS_MINUTE, 8'h3b);
      wr_reg(`CCA_OFS_HOUR, 8'h17);
      wr_reg(`CCA_OFS_DAY, cd[k]);
      wr_reg(`CCA_OFS_MONTH, cm[k]);
      wr_reg(`CCA_OFS_YEAR, cy[k]);
      wr_reg(`CCA_OFS_WEEKDAY, 8'h06);
      rd_reg(`CCA_OFS_FLAGS, v);
      wr_reg(`CCA_OFS_CTRL2, 8'h01);
      v = cd[k];
      for (int i = 0; i < 300 && v === cd[k]; i++) rd_reg(`CCA_OFS_DAY, v);
      wr_reg(`CCA_OFS_CTRL2, 8'h00);
      d = cd[k] + 1;
      m = cm[k];
      y = cy[k];
      if (d > mlen(m, y)) begin
        d = 1;
        m++;
      end
      if (m > 12) begin
        m = 1;
        y++;
      end
      if (y > 199) y = 1;
      rdx(`CCA_OFS_DAY, 8'(d));
      rdx(`CCA_OFS_MONTH, 8'(m));
      rdx(`CCA_OFS_YEAR, 8'(y));
      rdx(`CCA_OFS_WEEKDAY, 8'h00);
      rdx(`CCA_OFS_HOUR, 8'h00);
      chk1(irq, 1'b0);
      rd_reg(`CCA_OFS_FLAGS, v);
      chk8(v & 8'h0f, 8'h0f);
    end
    // alarm at 12:34 with only the alarm interrupt enabled
    wr_reg(`CCA_OFS_SECOND, 8'h3b);
    wr_reg(`CCA_OFS_MINUTE, 8'h21);
    wr_reg(`CCA_OFS_HOUR, 8'h0c);
    wr_reg(`CCA_OFS_IRQ_EN, 8'h10);
    wr_reg(`CCA_OFS_CTRL2, 8'h01);
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(negedge clock);
    wr_reg(`CCA_OFS_CTRL2, 8'h00);
    chk1(irq, 1'b1);
    rd_reg(`CCA_OFS_FLAGS, v);
    chk8(v & 8'h10, 8'h10);
    chk1(irq, 1'b0);
    // timebase flags: 4 Hz through the interrupt, then both flags
    wr_reg(`CCA_OFS_IRQ_EN, 8'h40);
    wr_reg(`CCA_OFS_CTRL2, 8'h01);
    for (int i = 0; i < 120 && irq !== 1'b1; i++) @(negedge clock);
    chk1(irq, 1'b1);
    repeat (220) @(posedge clock);
    wr_reg(`CCA_OFS_CTRL2, 8'h00);
    rd_reg(`CCA_OFS_FLAGS, v);
    chk8(v & 8'h60, 8'h60);
    // stopwatch load, clear, count and hold
    w = 8'($unsigned($random(seed)) % 100);
    wr_reg(`CCA_OFS_STOPWATCH, w);
    rdx(`CCA_OFS_STOPWATCH, w);
    rd_reg(`CCA_OFS_SECOND, v);
    wr_reg(`CCA_OFS_CTRL2, 8'h04);
    rdx(`CCA_OFS_STOPWATCH, 8'h00);
    rdx(`CCA_OFS_CTRL2, 8'h00);
    rdx(`CCA_OFS_SECOND, v);
    wr_reg(`CCA_OFS_CTRL2, 8'h03);
    repeat (40) @(posedge clock);
    wr_reg(`CCA_OFS_CTRL2, 8'h01);
    rd_reg(`CCA_OFS_STOPWATCH, v);
    chk1(v inside {[8'h09:8'h0c]}, 1'b1);
    repeat (40) @(posedge clock);
    rdx(`CCA_OFS_STOPWATCH, v);
    // module off freezes everything, stopwatch enable alone does nothing
    wr_reg(`CCA_OFS_CTRL2, 8'h02);
    rd_reg(`CCA_OFS_SECOND, w);
    repeat (500) @(posedge clock);
    rdx(`CCA_OFS_SECOND, w);
    rdx(`CCA_OFS_STOPWATCH, v);
    // second reset in mid-run
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rdx(`CCA_OFS_CTRL2, 8'h00);
    finish_test();
  end
endmodule
